// ### rtl/rmt_timer.sv
// Functional notes
// - Reading timer-low returns the live timer bits 7:0.
// - While running, timer-low writes wait pending until timer-high is written.
// - Idle: timer-low write loads the timer's low byte directly.
// - Compare event when selected timer byte equals compare; resets 0x00.
// - Overflow count adds one when the timer reaches or passes period.
// - Middle/high overflow reads give values latched at the last low read.
// - Overflow count write forces all 20 bits, idle or running.
// - Load coinciding with an increment stores written value plus one.
// - Low/middle overflow bytes apply only when the high byte is written.
// - Period-high write sets period bits 15:8; resets to 0xFF.
// - Period-high read returns captured timer bits 15:8.
// - Compare source select: 0 picks timer upper byte, 1 the lower.
// - Timer is idle or running; run status reads 1 while running, including a delta halt.
// - Timer-high read returns upper byte latched at the last timer-low read.
`timescale 1ns/1ps
module rmt_timer #(
  parameter int OVF_W = rmt_pkg::RMT_OVF_W
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire rmt_pkg::rmt_apb_req_t apb_in,
  input wire logic capture_in,
  output rmt_pkg::rmt_apb_rsp_t apb_out,
  output logic irq_out
);
  import rmt_pkg::*;

  typedef struct packed {
    rmt_run_t run;
    logic run_req;
    logic sel;
    logic [RMT_TIMER_W-1:0] timer;
    logic [RMT_TIMER_W-1:0] halt;
    logic [7:0] tlow_pend;
    logic [7:0] thigh_latch;
    logic [7:0] cmp;
    logic [RMT_TIMER_W-1:0] period;
    logic [RMT_TIMER_W-1:0] cap;
    logic [7:0] ofl_pend;
    logic [7:0] ofm_pend;
    logic [1:0] irq_st;
    logic [1:0] irq_msk;
    logic irq;
    logic pready;
    logic pslverr;
    logic [RMT_DATA_W-1:0] prdata;
  } rmt_state_t;

  localparam rmt_state_t RMT_STATE_RST = '{
    run: RMT_IDLE,
    run_req: 1'b0,
    sel: 1'b0,
    timer: '0,
    halt: '0,
    tlow_pend: RMT_BYTE_RST,
    thigh_latch: RMT_BYTE_RST,
    cmp: RMT_CMP_RST,
    period: {RMT_PERH_RST, RMT_PERL_RST},
    cap: '0,
    ofl_pend: RMT_BYTE_RST,
    ofm_pend: RMT_BYTE_RST,
    irq_st: '0,
    irq_msk: '0,
    irq: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: '0
  };

  rmt_state_t s_q;
  rmt_state_t s_d;

  logic [7:0] idx;
  logic mapped;
  logic acc;
  logic rd;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rbyte;
  logic advance;
  logic per_ev;
  logic cmp_ev;
  logic ovf_load;
  logic [OVF_W-1:0] ovf_load_val;
  logic ovf_snap;
  logic [OVF_W-1:0] ovf_count;
  logic [OVF_W-1:0] ovf_snapv;

  if (OVF_W < 17 || OVF_W > 24)
  begin : g_chk
    $error("rmt_timer: OVF_W must lie in 17..24");
  end

  function automatic logic [7:0] sel_byte(input logic [15:0] t,
                                           input logic lo);
    return lo ? t[7:0] : t[15:8];
  endfunction

  function automatic logic reg_mapped(input logic [7:0] i);
    case (i)
      RMT_IDX_CMP, RMT_IDX_OFL, RMT_IDX_OFM, RMT_IDX_OFH,
      RMT_IDX_PERL, RMT_IDX_PERH, RMT_IDX_TLOW, RMT_IDX_THIGH,
      RMT_IDX_CFG, RMT_IDX_IRQST, RMT_IDX_IRQMSK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  rmt_ovf_count #(
    .OVF_W(OVF_W)
  ) u_ovf (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .inc_in(per_ev),
    .load_in(ovf_load),
    .load_val_in(ovf_load_val),
    .snap_in(ovf_snap),
    .count_out(ovf_count),
    .snap_out(ovf_snapv)
  );

  always_comb
  begin
    s_d = s_q;
    idx = apb_in.paddr[9:2];
    mapped = reg_mapped(idx) && apb_in.paddr[1:0] == 2'b00
      && apb_in.paddr[RMT_ADDR_W-1:10] == '0;
    acc = apb_in.psel && apb_in.penable;
    // Reads act when pready rises so data and latches agree
    rd = acc && !s_q.pready && !apb_in.pwrite && mapped;
    wr = acc && s_q.pready && apb_in.pwrite && mapped;
    wdata = apb_in.pwdata[7:0];
    rbyte = 8'h00;
    advance = 1'b0;
    per_ev = 1'b0;
    cmp_ev = 1'b0;
    ovf_load = 1'b0;
    ovf_load_val = '0;
    ovf_snap = 1'b0;

    // Timer stepping; one clock per count
    s_d.run = s_q.run_req ? RMT_RUN : RMT_IDLE;
    if (s_q.run == RMT_RUN)
    begin
      if (s_q.halt != '0)
      begin
        s_d.halt = s_q.halt - 16'h0001;
      end
      else if (s_q.timer >= s_q.period)
      begin
        s_d.timer = '0;
        per_ev = 1'b1;
        advance = 1'b1;
      end
      else
      begin
        s_d.timer = s_q.timer + 16'h0001;
        advance = 1'b1;
      end
    end
    else
    begin
      s_d.halt = '0;
    end
    cmp_ev = advance && sel_byte(s_d.timer, s_q.sel) == s_q.cmp;

    if (capture_in)
    begin
      s_d.cap = s_q.timer;
    end

    // Register writes, taken at the completing edge
    if (wr)
    begin
      case (idx)
        RMT_IDX_CMP: s_d.cmp = wdata;
        RMT_IDX_OFL: s_d.ofl_pend = wdata;
        RMT_IDX_OFM: s_d.ofm_pend = wdata;
        RMT_IDX_OFH:
        begin
          ovf_load = 1'b1;
          ovf_load_val = OVF_W'({wdata, s_q.ofm_pend, s_q.ofl_pend});
        end
        RMT_IDX_PERL: s_d.period[7:0] = wdata;
        RMT_IDX_PERH: s_d.period[15:8] = wdata;
        RMT_IDX_TLOW:
        begin
          s_d.tlow_pend = wdata;
          if (s_q.run == RMT_IDLE)
          begin
            s_d.timer[7:0] = wdata;
          end
        end
        RMT_IDX_THIGH:
        begin
          if (s_q.run == RMT_RUN)
          begin
            s_d.halt = {wdata, s_q.tlow_pend};
          end
          else
          begin
            s_d.timer[15:8] = wdata;
          end
        end
        RMT_IDX_CFG:
        begin
          s_d.run_req = wdata[RMT_CFG_RUN_BIT];
          s_d.sel = wdata[RMT_CFG_SEL_BIT];
        end
        RMT_IDX_IRQMSK: s_d.irq_msk = wdata[1:0];
        default: s_d.cmp = s_q.cmp;
      endcase
    end

    // Read data, registered with pready
    case (idx)
      RMT_IDX_CMP: rbyte = s_q.cmp;
      RMT_IDX_OFL: rbyte = ovf_count[7:0];
      RMT_IDX_OFM: rbyte = ovf_snapv[15:8];
      RMT_IDX_OFH: rbyte = 8'(ovf_snapv >> 16);
      RMT_IDX_PERL: rbyte = s_q.cap[7:0];
      RMT_IDX_PERH: rbyte = s_q.cap[15:8];
      RMT_IDX_TLOW: rbyte = s_q.timer[7:0];
      RMT_IDX_THIGH: rbyte = s_q.thigh_latch;
      RMT_IDX_CFG:
        rbyte = {4'h0, s_q.sel, 2'b00, s_q.run == RMT_RUN};
      RMT_IDX_IRQST: rbyte = {6'h00, s_q.irq_st};
      RMT_IDX_IRQMSK: rbyte = {6'h00, s_q.irq_msk};
      default: rbyte = 8'h00;
    endcase
    if (rd && idx == RMT_IDX_TLOW)
    begin
      s_d.thigh_latch = s_q.timer[15:8];
    end
    ovf_snap = rd && idx == RMT_IDX_OFL;

    // Sticky events; an event in the clearing read still lands
    if (rd && idx == RMT_IDX_IRQST)
    begin
      s_d.irq_st = '0;
    end
    s_d.irq_st[RMT_IRQ_CMP_BIT] = s_d.irq_st[RMT_IRQ_CMP_BIT] | cmp_ev;
    s_d.irq_st[RMT_IRQ_PER_BIT] = s_d.irq_st[RMT_IRQ_PER_BIT] | per_ev;
    s_d.irq = |(s_d.irq_st & s_d.irq_msk);

    // Access answered on its second cycle
    s_d.pready = acc && !s_q.pready;
    s_d.pslverr = acc && !s_q.pready && !mapped;
    if (acc && !s_q.pready)
    begin
      s_d.prdata = (mapped && !apb_in.pwrite) ? {24'h000000, rbyte} : '0;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_q <= RMT_STATE_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign apb_out.prdata = s_q.prdata;
  assign apb_out.pready = s_q.pready;
  assign apb_out.pslverr = s_q.pslverr;
  assign irq_out = s_q.irq;

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);

  tlow_read_a: assert property (
    rd && idx == RMT_IDX_TLOW |=>
      apb_out.pready && apb_out.prdata[7:0] == $past(s_q.timer[7:0]))
    else $error("timer-low read data wrong");

  halt_hold_a: assert property (
    s_q.run == RMT_RUN && s_q.halt != '0 && !wr |=>
      s_q.timer == $past(s_q.timer) && s_q.halt == $past(s_q.halt) - 1)
    else $error("timer moved during delta halt");

  delta_load_a: assert property (
    wr && idx == RMT_IDX_THIGH && s_q.run == RMT_RUN |=>
      s_q.halt == {$past(wdata), $past(s_q.tlow_pend)})
    else $error("delta not formed from pending low byte");

  idle_low_a: assert property (
    wr && idx == RMT_IDX_TLOW && s_q.run == RMT_IDLE |=>
      s_q.timer[7:0] == $past(wdata))
    else $error("idle low write not loaded");

  cmp_flag_a: assert property (
    s_q.run == RMT_RUN && s_q.halt == '0 && !wr
      && sel_byte(s_d.timer, s_q.sel) == s_q.cmp |=>
      s_q.irq_st[RMT_IRQ_CMP_BIT])
    else $error("compare match not flagged");

  period_wrap_a: assert property (
    s_q.run == RMT_RUN && s_q.halt == '0 && s_q.timer >= s_q.period
      && !wr |=> s_q.timer == '0 && ovf_count == $past(ovf_count) + 1'b1)
    else $error("period wrap or overflow increment missing");

  ovf_load_a: assert property (
    ovf_load |=> ovf_count == $past(ovf_load_val) + $past(per_ev))
    else $error("overflow load lost value or increment");

  ovf_snap_a: assert property (
    rd && idx == RMT_IDX_OFL |=> ovf_snapv == $past(ovf_count))
    else $error("overflow snapshot not taken at low read");

  ovf_mid_a: assert property (
    rd && idx == RMT_IDX_OFM |=>
      apb_out.prdata[7:0] == $past(ovf_snapv[15:8]))
    else $error("middle overflow byte not from snapshot");

  perh_write_a: assert property (
    wr && idx == RMT_IDX_PERH |=> s_q.period[15:8] == $past(wdata))
    else $error("period high not written");

  cap_read_a: assert property (
    rd && idx == RMT_IDX_PERH |=> apb_out.prdata[7:0] == $past(s_q.cap[15:8]))
    else $error("period-high read not capture");

  run_stat_a: assert property (
    rd && idx == RMT_IDX_CFG |=>
      apb_out.prdata[RMT_CFG_RUN_BIT] == $past(s_q.run == RMT_RUN))
    else $error("run status mismatch");

  high_latch_a: assert property (
    rd && idx == RMT_IDX_TLOW |=> s_q.thigh_latch == $past(s_q.timer[15:8]))
    else $error("timer high not latched");

  period_wrap_c: cover property (per_ev ##1 irq_out);
  delta_halt_c: cover property (wr && idx == RMT_IDX_THIGH
    && s_q.run == RMT_RUN ##1 s_q.halt != '0);
  load_inc_c: cover property (ovf_load && per_ev);
  cmp_hit_c: cover property (cmp_ev);

endmodule

// ### rtl/rmt_pkg.sv
package rmt_pkg;

  localparam int RMT_ADDR_W = 12;
  localparam int RMT_DATA_W = 32;
  localparam int RMT_TIMER_W = 16;
  localparam int RMT_OVF_W = 20;

  // Register indices; byte address is four times the index
  localparam logic [7:0] RMT_IDX_CMP = 8'h94;
  localparam logic [7:0] RMT_IDX_OFL = 8'hA1;
  localparam logic [7:0] RMT_IDX_OFM = 8'hA2;
  localparam logic [7:0] RMT_IDX_OFH = 8'hA3;
  localparam logic [7:0] RMT_IDX_PERL = 8'hA4;
  localparam logic [7:0] RMT_IDX_PERH = 8'hA5;
  localparam logic [7:0] RMT_IDX_TLOW = 8'hA6;
  localparam logic [7:0] RMT_IDX_THIGH = 8'hA7;
  localparam logic [7:0] RMT_IDX_CFG = 8'hB0;
  localparam logic [7:0] RMT_IDX_IRQST = 8'hB1;
  localparam logic [7:0] RMT_IDX_IRQMSK = 8'hB2;

  localparam int RMT_CFG_RUN_BIT = 0;
  localparam int RMT_CFG_SEL_BIT = 3;
  localparam int RMT_IRQ_CMP_BIT = 0;
  localparam int RMT_IRQ_PER_BIT = 1;

  localparam logic [7:0] RMT_CMP_RST = 8'h00;
  localparam logic [7:0] RMT_PERH_RST = 8'hFF;
  localparam logic [7:0] RMT_PERL_RST = 8'hFF;
  localparam logic [7:0] RMT_BYTE_RST = 8'h00;

  typedef enum logic {RMT_IDLE, RMT_RUN} rmt_run_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [RMT_ADDR_W-1:0] paddr;
    logic [RMT_DATA_W-1:0] pwdata;
  } rmt_apb_req_t;

  typedef struct packed {
    logic [RMT_DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } rmt_apb_rsp_t;

endpackage

// ### rtl/rmt_ovf_count.sv
`timescale 1ns/1ps
module rmt_ovf_count #(
  parameter int OVF_W = rmt_pkg::RMT_OVF_W
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic inc_in,
  input wire logic load_in,
  input wire logic [OVF_W-1:0] load_val_in,
  input wire logic snap_in,
  output logic [OVF_W-1:0] count_out,
  output logic [OVF_W-1:0] snap_out
);
  import rmt_pkg::*;

  typedef struct packed {
    logic [OVF_W-1:0] count;
    logic [OVF_W-1:0] snap;
  } rmt_ovf_state_t;

  rmt_ovf_state_t s_q;
  rmt_ovf_state_t s_d;

  if (OVF_W < 17 || OVF_W > 24)
  begin : g_chk
    $error("rmt_ovf_count: OVF_W must lie in 17..24");
  end

  always_comb
  begin
    s_d = s_q;
    // A load that meets an increment keeps the increment
    if (load_in)
    begin
      s_d.count = load_val_in + OVF_W'(inc_in);
    end
    else if (inc_in)
    begin
      s_d.count = s_q.count + OVF_W'(1);
    end
    if (snap_in)
    begin
      s_d.snap = s_q.count;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign count_out = s_q.count;
  assign snap_out = s_q.snap;

endmodule

// ### tb/rmt_timer_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    samples_checked++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); \
    end \
  end
module rmt_timer_tb;
  import rmt_pkg::*;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic capture_in = 1'b0;
  logic irq;
  rmt_apb_req_t req = '0;
  rmt_apb_rsp_t rsp;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] rd;
  logic err;
  logic [15:0] d0, d1;

  always #12.5 clock_in = ~clock_in;

  rmt_timer i_rmt_timer (
    .clock_in(clock_in),
    .arst_n_in(arst_n_in),
    .apb_in(req),
    .capture_in(capture_in),
    .apb_out(rsp),
    .irq_out(irq)
  );

  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // Idle cycle after each transfer so psel is never reassigned in one step
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] d);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= {2'b00, idx, 2'b00};
    req.pwdata <= {24'h000000, d};
    @(posedge clock_in);
    req.penable <= 1'b1;
    do @(posedge clock_in); while (rsp.pready !== 1'b1);
    rd = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock_in);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    `CHK(rd, exp)
  endtask

  task automatic load_timer(input logic [15:0] v);
    wr(RMT_IDX_TLOW, v[7:0]);
    wr(RMT_IDX_THIGH, v[15:8]);
  endtask

  task automatic t_reset;
    rdc(RMT_IDX_CMP, 8'h00);
    rdc(RMT_IDX_OFL, 8'h00);
    rdc(RMT_IDX_CFG, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    `CHK(err, 1'b1)
    `CHK(irq, 1'b0)
  endtask

  task automatic t_idle_load;
    load_timer(16'h1234);
    rdc(RMT_IDX_TLOW, 8'h34);
    rdc(RMT_IDX_THIGH, 8'h12);
    wr(RMT_IDX_TLOW, 8'h56);
    rdc(RMT_IDX_TLOW, 8'h56);
  endtask

  task automatic t_ovf;
    wr(RMT_IDX_OFL, 8'h56);
    wr(RMT_IDX_OFM, 8'h34);
    rdc(RMT_IDX_OFL, 8'h00);
    wr(RMT_IDX_OFH, 8'hF5);
    rdc(RMT_IDX_OFL, 8'h56);
    wr(RMT_IDX_OFL, 8'h00);
    wr(RMT_IDX_OFM, 8'h99);
    wr(RMT_IDX_OFH, 8'h00);
    rdc(RMT_IDX_OFM, 8'h34);
    rdc(RMT_IDX_OFH, 8'h05);
  endtask

  // Period 16: one wrap per 17 cycles; start/stop slack allows 5..7
  task automatic t_period;
    wr(RMT_IDX_PERH, 8'h00);
    wr(RMT_IDX_PERL, 8'h10);
    load_timer(16'h0000);
    wr(RMT_IDX_OFL, 8'h00);
    wr(RMT_IDX_OFM, 8'h00);
    wr(RMT_IDX_OFH, 8'h00);
    wr(RMT_IDX_IRQMSK, 8'h02);
    wr(RMT_IDX_CFG, 8'h01);
    rdc(RMT_IDX_CFG, 8'h01);
    repeat (100) @(posedge clock_in);
    wr(RMT_IDX_CFG, 8'h00);
    `CHK(irq, 1'b1)
    apb(1'b0, RMT_IDX_TLOW, 8'h00);
    `CHK(rd <= 8'h10, 1'b1)
    apb(1'b0, RMT_IDX_OFL, 8'h00);
    `CHK(rd >= 8'h05 && rd <= 8'h07, 1'b1)
    apb(1'b0, RMT_IDX_IRQST, 8'h00);
    `CHK(rd[RMT_IRQ_PER_BIT], 1'b1)
    repeat (2) @(posedge clock_in);
    `CHK(irq, 1'b0)
    rdc(RMT_IDX_IRQST, 8'h00);
  endtask

  task automatic t_compare;
    wr(RMT_IDX_CMP, 8'h05);
    wr(RMT_IDX_PERH, 8'hFF);
    wr(RMT_IDX_PERL, 8'hFF);
    wr(RMT_IDX_IRQMSK, 8'h00);
    load_timer(16'h0000);
    wr(RMT_IDX_CFG, 8'h09);
    repeat (20) @(posedge clock_in);
    wr(RMT_IDX_CFG, 8'h08);
    `CHK(irq, 1'b0)
    rdc(RMT_IDX_IRQST, 8'h01);
    load_timer(16'h0000);
    wr(RMT_IDX_CFG, 8'h01);
    repeat (20) @(posedge clock_in);
    wr(RMT_IDX_CFG, 8'h00);
    rdc(RMT_IDX_IRQST, 8'h00);
  endtask

  // Same bus traffic with two deltas; only the halt length differs
  task automatic measure(input logic [7:0] delta, output logic [15:0] diff);
    logic [15:0] a;
    load_timer(16'h0000);
    wr(RMT_IDX_CFG, 8'h01);
    apb(1'b0, RMT_IDX_TLOW, 8'h00);
    a[7:0] = rd;
    apb(1'b0, RMT_IDX_THIGH, 8'h00);
    a[15:8] = rd;
    wr(RMT_IDX_TLOW, delta);
    wr(RMT_IDX_THIGH, 8'h00);
    repeat (40) @(posedge clock_in);
    apb(1'b0, RMT_IDX_TLOW, 8'h00);
    diff[7:0] = rd;
    apb(1'b0, RMT_IDX_THIGH, 8'h00);
    diff[15:8] = rd;
    diff = diff - a;
    wr(RMT_IDX_CFG, 8'h00);
  endtask

  task automatic t_delta;
    measure(8'h00, d0);
    measure(8'h20, d1);
    `CHK(d0 - d1, 16'h0020)
  endtask

  task automatic t_capture;
    load_timer(16'h3400);
    wr(RMT_IDX_CFG, 8'h01);
    capture_in <= 1'b1;
    @(posedge clock_in);
    capture_in <= 1'b0;
    @(posedge clock_in);
    wr(RMT_IDX_CFG, 8'h00);
    rdc(RMT_IDX_PERH, 8'h34);
  endtask

  initial
  begin
    repeat (2) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    t_reset();
    t_idle_load();
    t_ovf();
    t_period();
    t_compare();
    t_delta();
    t_capture();
    tally_and_finish();
  end
endmodule
